// *** logic/scg_clock_map.vh ***
`ifndef SCG_CLOCK_MAP_VH
`define SCG_CLOCK_MAP_VH
// Mode select codes.
`define SCG_MODE_SYNC 1'b0
`define SCG_MODE_ASYNC 1'b1
// Asynchronous source select codes.
`define SCG_SRC_TIMER 2'h0
`define SCG_SRC_GEN 2'h1
`define SCG_SRC_SYS 2'h2
`define SCG_SRC_PIN 2'h3
// Generator input select codes and prescaler tap ratios.
`define SCG_TAP_DIV2 2'h0
`define SCG_TAP_DIV8 2'h1
`define SCG_TAP_DIV32 2'h2
`define SCG_TAP_DIV128 2'h3
`define SCG_TAP_RATIO2 8'h02
`define SCG_TAP_RATIO8 8'h08
`define SCG_TAP_RATIO32 8'h20
`define SCG_TAP_RATIO128 8'h80
// Bit period in channel clocks for asynchronous mode.
`define SCG_OVERSAMPLE 5'h10
// Prescaler width and reset values.
`define SCG_PRESCALE_W 7
`define SCG_PRESCALE_RST 7'h00
`define SCG_GEN_CNT_RST 4'h0
`endif

// *** logic/scg_fractional_divider.v ***
`include "scg_clock_map.vh"

module scg_fractional_divider (
  // Clock and reset.
  input wire REF_CLK,
  input wire RSTN,
  // Control.
  input wire tick_in,
  input wire [3:0] n_code,
  input wire [3:0] k_value,
  input wire frac_en,
  // Output.
  output reg tick_out
);
  reg [4:0] cnt_reg;
  reg [3:0] phase_reg;
  wire [4:0] n_val;
  wire stretch;
  wire [4:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Code 0 stands for sixteen so that N covers one through sixteen.
  assign n_val = (n_code == 4'h0) ? 5'h10 : {1'b0, n_code};
  // The first 16-K of each sixteen periods take one extra input tick.
  assign stretch = frac_en && (k_value != 4'h0) &&
                   ({1'b0, phase_reg} < (5'h10 - {1'b0, k_value}));
  assign limit = stretch ? n_val : (n_val - 5'h01);

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_reg <= 5'h00;
      phase_reg <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_reg >= limit) begin
          cnt_reg <= 5'h00;
          tick_out <= 1'b1;
          phase_reg <= phase_reg + 4'h1;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end
endmodule // scg_fractional_divider

// *** logic/scg_serial_clock_gen.v ***
`include "scg_clock_map.vh"

module scg_serial_clock_gen #(
  parameter TIMER_W = 16
) (
  // Clock and reset.
  input wire REF_CLK,
  input wire RSTN,
  // Mode and source controls.
  input wire CHANNEL_MODE_SELECT,
  input wire [1:0] ASYNC_CLOCK_SOURCE_SELECT,
  input wire CLOCK_PIN_IS_INPUT,
  input wire EDGE_SELECT_FALLING,
  // Generator controls.
  input wire [1:0] GENERATOR_INPUT_SELECT,
  input wire [3:0] GENERATOR_DIVIDE_N,
  input wire [3:0] GENERATOR_FRACTION_K,
  input wire FRACTIONAL_ENABLE,
  // Timer source.
  input wire TIMER_PRESCALE_TICK,
  input wire [TIMER_W-1:0] TIMER_COMPARE_VALUE,
  // External serial clock pin, taken as synchronous.
  input wire SERIAL_CLOCK_IN,
  // Outputs.
  output reg SERIAL_SHIFT_CLOCK,
  output reg BIT_TICK,
  output reg SERIAL_CLOCK_OUT,
  output reg SERIAL_CLOCK_OE_N,
  output reg TIMER_FLIP_FLOP
);
  reg [`SCG_PRESCALE_W-1:0] prescale_reg;
  reg tap_tick_reg;
  reg [TIMER_W-1:0] timer_cnt_reg;
  reg timer_ff_prev_reg;
  reg pin_prev_reg;
  reg gen_half_reg;
  reg [3:0] bit_cnt_reg;
  reg shift_next;
  wire gen_tick;
  wire [`SCG_PRESCALE_W-1:0] prescale_next;
  wire timer_match;
  wire timer_edge;
  wire pin_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Tap decode returns the mask of low prescaler bits that must all be set.
  function [`SCG_PRESCALE_W-1:0] tap_mask;
    input [1:0] sel;
    reg [7:0] full_mask;
    begin
      case (sel)
        `SCG_TAP_DIV2: full_mask = `SCG_TAP_RATIO2 - 8'h01;
        `SCG_TAP_DIV8: full_mask = `SCG_TAP_RATIO8 - 8'h01;
        `SCG_TAP_DIV32: full_mask = `SCG_TAP_RATIO32 - 8'h01;
        default: full_mask = `SCG_TAP_RATIO128 - 8'h01;
      endcase
      // The largest ratio minus one still fits the prescaler width.
      tap_mask = full_mask[`SCG_PRESCALE_W-1:0];
    end
  endfunction

  assign prescale_next = prescale_reg + 7'h01;

  // One system-clock tick per tap period keeps all logic on REF_CLK.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prescale_reg <= `SCG_PRESCALE_RST;
      tap_tick_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      tap_tick_reg <= ((prescale_reg & tap_mask(GENERATOR_INPUT_SELECT)) ==
                       tap_mask(GENERATOR_INPUT_SELECT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fractional division is honoured only in asynchronous mode.
  scg_fractional_divider u_div (
    .REF_CLK(REF_CLK),
    .RSTN(RSTN),
    .tick_in(tap_tick_reg),
    .n_code(GENERATOR_DIVIDE_N),
    .k_value(GENERATOR_FRACTION_K),
    .frac_en(FRACTIONAL_ENABLE && (CHANNEL_MODE_SELECT == `SCG_MODE_ASYNC)),
    .tick_out(gen_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timer source: a compare match reloads the counter with one and flips the flop.
  assign timer_match = TIMER_PRESCALE_TICK && (timer_cnt_reg >= TIMER_COMPARE_VALUE);

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_cnt_reg <= {TIMER_W{1'b0}};
      TIMER_FLIP_FLOP <= 1'b0;
      timer_ff_prev_reg <= 1'b0;
    end else begin
      timer_ff_prev_reg <= TIMER_FLIP_FLOP;
      if (timer_match) begin
        timer_cnt_reg <= {{(TIMER_W-1){1'b0}}, 1'b1};
        TIMER_FLIP_FLOP <= ~TIMER_FLIP_FLOP;
      end else if (TIMER_PRESCALE_TICK) begin
        timer_cnt_reg <= timer_cnt_reg + {{(TIMER_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // A rising flop edge marks one channel clock, i.e. every second toggle.
  assign timer_edge = TIMER_FLIP_FLOP && !timer_ff_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detect; the pin is treated as synchronous, so no synchroniser.
  // The pin must run slower than a few system periods or edges are missed.
  assign pin_edge = EDGE_SELECT_FALLING ? (pin_prev_reg && !SERIAL_CLOCK_IN) :
                    (!pin_prev_reg && SERIAL_CLOCK_IN);

  // Select the working clock event for the current mode.
  always @* begin
    shift_next = 1'b0;
    case (CHANNEL_MODE_SELECT)
      `SCG_MODE_SYNC: begin
        if (CLOCK_PIN_IS_INPUT) begin
          shift_next = pin_edge;
        end else begin
          shift_next = gen_tick && gen_half_reg;
        end
      end
      default: begin
        case (ASYNC_CLOCK_SOURCE_SELECT)
          `SCG_SRC_TIMER: shift_next = timer_edge;
          `SCG_SRC_GEN: shift_next = gen_tick;
          `SCG_SRC_SYS: shift_next = 1'b1;
          default: shift_next = pin_edge;
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_prev_reg <= 1'b0;
      gen_half_reg <= 1'b0;
      bit_cnt_reg <= `SCG_GEN_CNT_RST;
      SERIAL_SHIFT_CLOCK <= 1'b0;
      BIT_TICK <= 1'b0;
      SERIAL_CLOCK_OUT <= 1'b1;
      SERIAL_CLOCK_OE_N <= 1'b1;
    end else begin
      pin_prev_reg <= SERIAL_CLOCK_IN;
      SERIAL_SHIFT_CLOCK <= shift_next;
      BIT_TICK <= 1'b0;
      // The driven pin toggles every generator tick, giving half the rate.
      if (gen_tick) begin
        gen_half_reg <= ~gen_half_reg;
      end
      SERIAL_CLOCK_OUT <= ~gen_half_reg;
      SERIAL_CLOCK_OE_N <= !((CHANNEL_MODE_SELECT == `SCG_MODE_SYNC) && !CLOCK_PIN_IS_INPUT);
      if (CHANNEL_MODE_SELECT == `SCG_MODE_SYNC) begin
        bit_cnt_reg <= `SCG_GEN_CNT_RST;
        BIT_TICK <= shift_next;
      end else if (shift_next) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        BIT_TICK <= (bit_cnt_reg == (`SCG_OVERSAMPLE - 5'h01));
      end
    end
  end
endmodule // scg_serial_clock_gen

// *** sim/scg_serial_clock_gen_assertions.sv ***
module scg_sva (
  // Clock and reset.
  input logic REF_CLK,
  input logic RSTN,
  // Controls.
  input logic CHANNEL_MODE_SELECT,
  input logic [1:0] ASYNC_CLOCK_SOURCE_SELECT,
  input logic CLOCK_PIN_IS_INPUT,
  input logic EDGE_SELECT_FALLING,
  input logic TIMER_PRESCALE_TICK,
  input logic SERIAL_CLOCK_IN,
  // Outputs.
  input logic SERIAL_SHIFT_CLOCK,
  input logic BIT_TICK,
  input logic SERIAL_CLOCK_OUT,
  input logic SERIAL_CLOCK_OE_N,
  input logic TIMER_FLIP_FLOP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  wire sy = !CHANNEL_MODE_SELECT;
  wire pi = sy && CLOCK_PIN_IS_INPUT;
  wire po = sy && !CLOCK_PIN_IS_INPUT;
  sequence s_shift; ##[1:3] SERIAL_SHIFT_CLOCK; endsequence
  sequence s_gap; !BIT_TICK [*8] ##1 !BIT_TICK [*7]; endsequence
  property p_pulse; sy && SERIAL_SHIFT_CLOCK |=> !SERIAL_SHIFT_CLOCK; endproperty
  property p_rise; pi && !EDGE_SELECT_FALLING && $rose(SERIAL_CLOCK_IN) |-> s_shift; endproperty
  property p_fall; pi && EDGE_SELECT_FALLING && $fell(SERIAL_CLOCK_IN) |-> s_shift; endproperty
  property p_drv; po |=> !SERIAL_CLOCK_OE_N; endproperty
  property p_off; !po |=> SERIAL_CLOCK_OE_N; endproperty
  property p_out; po && $rose(SERIAL_CLOCK_OUT) |-> $past(SERIAL_SHIFT_CLOCK); endproperty
  property p_sys; !sy && ASYNC_CLOCK_SOURCE_SELECT == 2'h2 && BIT_TICK |=> s_gap ##1 BIT_TICK;
  endproperty
  property p_tmr;
    $changed(TIMER_FLIP_FLOP) |-> $past(TIMER_PRESCALE_TICK) || $past(TIMER_PRESCALE_TICK, 2);
  endproperty
  property p_sbit; sy && SERIAL_SHIFT_CLOCK |-> BIT_TICK; endproperty
  a_pulse: assert property (p_pulse) else $error("shift pulse too long");
  a_rise: assert property (p_rise) else $error("rising pin edge lost");
  a_fall: assert property (p_fall) else $error("falling pin edge lost");
  a_drv: assert property (p_drv) else $error("pin not driven");
  a_off: assert property (p_off) else $error("pin driven wrongly");
  a_out: assert property (p_out) else $error("no shift on pin rise");
  a_sys: assert property (p_sys) else $error("bit not 16 cycles");
  a_tmr: assert property (p_tmr) else $error("flop moved without tick");
  a_sbit: assert property (p_sbit) else $error("sync bit tick missing");
endmodule // scg_sva

// *** sim/scg_pin_partner.sv ***
module scg_pin_partner #(parameter int HALF = 5) (
  // Clock and frame enable.
  input logic clk,
  input logic run,
  // Serial clock to the block.
  output logic sclk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial sclk = 1'b0;
  // Stands low between frames; a period of ten system clocks stays legal in both modes.
  always @(posedge clk) begin
    if (!run || cnt == HALF - 1) cnt <= 0;
    else cnt <= cnt + 1;
    if (!run) sclk <= #1 1'b0;
    else if (cnt == HALF - 1) sclk <= #1 ~sclk;
  end
endmodule // scg_pin_partner

// *** sim/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 0, RSTN = 0, mode = 0, pin_in = 0, fall = 0, frac = 0, tick = 0, run = 0;
  logic [1:0] src = 2'h0, tap = 2'h0;
  logic [3:0] n = 4'h1, k = 4'h0;
  logic [15:0] cmp = 16'h0002;
  logic sck, shf, bt, oe_n;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) tick <= #1 ~tick;
  scg_pin_partner ext (.clk(REF_CLK), .run(run), .sclk(sck));
  scg_serial_clock_gen dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .CHANNEL_MODE_SELECT(mode),
    .ASYNC_CLOCK_SOURCE_SELECT(src), .CLOCK_PIN_IS_INPUT(pin_in), .EDGE_SELECT_FALLING(fall),
    .GENERATOR_INPUT_SELECT(tap), .GENERATOR_DIVIDE_N(n), .GENERATOR_FRACTION_K(k),
    .FRACTIONAL_ENABLE(frac), .TIMER_PRESCALE_TICK(tick), .TIMER_COMPARE_VALUE(cmp),
    .SERIAL_CLOCK_IN(sck), .SERIAL_SHIFT_CLOCK(shf), .BIT_TICK(bt), .SERIAL_CLOCK_OUT(),
    .SERIAL_CLOCK_OE_N(oe_n), .TIMER_FLIP_FLOP());
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("BAD %0t period %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t level %b not %b", $time, got, exp);
    end
  endtask
  task automatic go();
    @(posedge REF_CLK);
    #1;
  endtask
  // The first two events after a change are skipped, as they may be partial.
  task automatic per(input logic use_bit, input int exp);
    int c;
    repeat (3) begin
      c = 0;
      do begin
        @(negedge REF_CLK);
        c++;
      end while ((use_bit ? bt : shf) !== 1'b1 && c < 3000);
    end
    chk_n(c, exp);
  endtask
  task automatic t_sync_out();
    for (int i = 0; i < 4; i++) begin
      go();
      // Every tap is at most half the system clock; divide-by-one assumes double buffering.
      tap = i[1:0];
      per(0, 4 << (2 * i));
    end
    go();
    tap = 2'h0;
    n = 4'h0;
    per(0, 64);
    go();
    n = 4'h3;
    per(0, 12);
    chk_b(oe_n, 1'b0);
  endtask
  task automatic t_sync_in();
    go();
    pin_in = 1'b1;
    run = 1'b1;
    per(0, 10);
    go();
    fall = 1'b1;
    per(0, 10);
    chk_b(oe_n, 1'b1);
  endtask
  task automatic t_async();
    go();
    mode = 1'b1;
    pin_in = 1'b0;
    fall = 1'b0;
    run = 1'b0;
    src = 2'h1;
    n = 4'h2;
    per(1, 64);
    go();
    frac = 1'b1;
    k = 4'h8;
    per(1, 80);
    go();
    src = 2'h0;
    per(1, 128);
    go();
    cmp = 16'h0003;
    per(1, 192);
    go();
    src = 2'h3;
    run = 1'b1;
    per(1, 160);
    go();
    src = 2'h2;
    per(1, 16);
    chk_b(oe_n, 1'b1);
  endtask
  // The clock gear is fixed for the whole run.
  initial begin
    repeat (4) @(posedge REF_CLK);
    #1 RSTN = 1'b1;
    t_sync_out();
    t_sync_in();
    t_async();
    end_of_test();
  end
endmodule // tb
bind scg_serial_clock_gen scg_sva sva (.*);
